/* File: hw/rfsc_fan_ctrl.sv */
// Top of the fan speed controller: timebase, regulation and spin-up.
`timescale 1ns/1ps
`include "rfsc_consts.svh"
module rfsc_fan_ctrl (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    input  wire logic       clk_strap_i,
    input  wire logic       ext_tb_i,
    input  wire logic [1:0] drive_strap_i,
    input  wire logic       tach_i,
    input  wire logic       alg_en_i,
    input  wire logic [7:0] target_i,
    input  wire logic [7:0] valid_limit_i,
    input  wire logic [7:0] manual_drive_i,
    input  wire logic       spin_level_75_i,
    input  wire logic [1:0] spin_time_i,
    input  wire logic [7:0] step_i,
    input  wire logic [7:0] min_drive_i,
    input  wire logic [2:0] update_sel_i,
    input  wire logic [1:0] poles_i,
    input  wire logic       stall_clear_i,
    input  wire logic       spin_fail_clear_i,
    output logic [7:0]      drive_o,
    output logic            driver_en_o,
    output logic [7:0]      tach_count_o,
    output logic            stall_o,
    output logic            spin_fail_o,
    output logic            ext_clk_sel_o,
    output logic            stall_irq_o
);
    // ========================================
    // Clock-source strap and timebase tick
    // ========================================
    logic        strap_done_reg;       // Straps caught once after reset.
    logic        strap_done_next;      // Next strap-caught flag.
    logic        ext_sel_reg;          // Latched clock-source choice.
    logic        ext_sel_next;         // Next clock-source choice.
    logic [1:0]  mode_strap_reg;       // Latched drive strap.
    logic [1:0]  mode_strap_next;      // Next drive strap.
    logic [10:0] div_reg;              // Internal timebase divider.
    logic [10:0] div_next;             // Next divider value.
    logic        ext_d_reg;            // Last external timebase level.
    logic        ext_d_next;           // Next external level.
    logic        tick;                 // One timebase period has passed.

    // Latches the straps on the first clock after reset, then holds them.
    always_comb begin
        strap_done_next = 1'b1;
        ext_sel_next    = strap_done_reg ? ext_sel_reg : clk_strap_i;
        mode_strap_next = strap_done_reg ? mode_strap_reg : drive_strap_i;
        div_next        = (div_reg == 11'(`RFSC_TB_DIV - 1)) ? 11'h000
                                                            : div_reg + 11'h001;
        ext_d_next      = ext_tb_i;
    end

    // Chooses internal divider or rising edge of the external timebase.
    assign tick = ext_sel_reg ? (ext_tb_i && !ext_d_reg)
                              : (div_reg == 11'h000);

    // Registers the strap latches, the divider and the external level.
    // The straps are caught once, so later pin changes are ignored.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            strap_done_reg <= 1'b0;
            ext_sel_reg    <= 1'b0;
            mode_strap_reg <= 2'h0;
            div_reg        <= 11'h000;
            ext_d_reg      <= 1'b0;
        end else begin
            strap_done_reg <= strap_done_next;
            ext_sel_reg    <= ext_sel_next;
            mode_strap_reg <= mode_strap_next;
            div_reg        <= div_next;
            ext_d_reg      <= ext_d_next;
        end
    end

    // ========================================
    // Tach measurement
    // ========================================
    logic [7:0] meas;                  // Latest count per revolution.

    // The capture strobe is not needed here: every check reads the
    // latest count, which holds until the next revolution or timeout is captured.

    rfsc_tach_meter u_meter (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .tick_i    (tick),
        .tach_i    (tach_i),
        .poles_i   (poles_i),
        .count_o   (meas),
        .done_o    ()
    );

    // ========================================
    // Millisecond ticks, spin time and update time
    // ========================================
    logic [5:0]  ms_reg;               // Ticks inside one millisecond.
    logic [5:0]  ms_next;              // Next millisecond count.
    logic        ms_tick;              // One millisecond passed.
    logic [11:0] spin_len;             // Spin time in milliseconds.
    logic [10:0] upd_len;              // Update period in milliseconds.

    assign ms_tick = tick && (ms_reg == 6'(`RFSC_MS_TICKS - 1));

    // Counts timebase ticks into milliseconds and decodes the spin and
    // update lengths; all timers below run in whole milliseconds.
    always_comb begin
        ms_next = tick ? (ms_tick ? 6'h00 : ms_reg + 6'h01) : ms_reg;
        case (spin_time_i)
            2'h0:    spin_len = `RFSC_SPIN_250MS;
            2'h1:    spin_len = `RFSC_SPIN_500MS;
            2'h2:    spin_len = `RFSC_SPIN_1S;
            default: spin_len = `RFSC_SPIN_2S;
        endcase
        upd_len = 11'(`RFSC_UPD_BASE << update_sel_i[1:0]); // Base times 2^n.
        if (update_sel_i[2]) begin
            upd_len = `RFSC_UPD_LONG;
        end
    end

    // Registers the millisecond counter.
    // It free-runs so that every timer sees the same millisecond grid.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ms_reg <= 6'h00;
        end else begin
            ms_reg <= ms_next;
        end
    end

    // ========================================
    // Regulation, spin-up and stall flags
    // ========================================
    rfsc_pkg::rfsc_state_e state_reg;  // Drive control state.
    rfsc_pkg::rfsc_state_e state_next; // Next control state.
    logic [7:0]  drive_reg;            // Drive level to the driver.
    logic [7:0]  drive_next;           // Next drive level.
    logic        en_reg;               // Driver enabled.
    logic        en_next;              // Next driver enable.
    logic [11:0] timer_reg;            // Spin or update timer in ms.
    logic [11:0] timer_next;           // Next timer value.
    logic [11:0] mask_reg;             // Manual stall mask time left.
    logic [11:0] mask_next;            // Next mask time.
    logic        alg_d_reg;            // Last algorithm enable.
    logic        alg_d_next;           // Next algorithm enable copy.
    logic [7:0]  man_d_reg;            // Last manual drive value.
    logic [7:0]  man_d_next;           // Next manual drive copy.
    logic [7:0]  tgt_d_reg;            // Last target value.
    logic [7:0]  tgt_d_next;           // Next target copy.
    logic        stall_reg;            // Sticky stall flag.
    logic        stall_next;           // Next stall flag.
    logic        fail_reg;             // Sticky spin-failure flag.
    logic        fail_next;            // Next failure flag.
    logic        over;                 // Measured count over the limit.
    logic        tgt_off;              // Target requests driver off.
    logic [7:0]  spin_lvl;             // Second-phase spin level.
    logic [8:0]  up_sum;               // Drive plus step.
    logic [8:0]  dn_dif;               // Drive minus step.
    logic        mask_go;              // Manual stall mask restarts now.
    logic        dn_floor;             // Step down would pass the minimum.

    assign over     = meas > valid_limit_i;
    assign tgt_off  = target_i == `RFSC_TARGET_OFF;
    assign spin_lvl = spin_level_75_i ? `RFSC_DRIVE_75 : `RFSC_DRIVE_60;
    assign up_sum   = {1'b0, drive_reg} + {1'b0, step_i};
    assign dn_dif   = {1'b0, drive_reg} - {1'b0, step_i};
    // Entering manual mode or leaving 00h restarts the stall mask; the
    // same cycle must not flag, or the mask would open one cycle late.
    assign mask_go  = !alg_en_i && (alg_d_reg
                      || (man_d_reg == `RFSC_DRIVE_ZERO
                          && manual_drive_i != `RFSC_DRIVE_ZERO));
    // Stepping down must neither wrap below zero nor pass the minimum.
    assign dn_floor = dn_dif[8] || dn_dif[7:0] < min_drive_i;

    // Computes drive, spin-up sequencing and the flags.
    always_comb begin
        state_next = state_reg;
        drive_next = drive_reg;
        en_next    = en_reg;
        timer_next = (ms_tick && timer_reg != 12'h000) ? timer_reg - 12'h001
                                                        : timer_reg;
        mask_next  = (ms_tick && mask_reg != 12'h000) ? mask_reg - 12'h001
                                                       : mask_reg;
        alg_d_next = alg_en_i;
        man_d_next = manual_drive_i;
        tgt_d_next = target_i;
        stall_next = stall_reg && !stall_clear_i;
        fail_next  = fail_reg && !spin_fail_clear_i;
        if (!alg_en_i) begin
            // Manual drive applies at once; spin-up stays out.
            drive_next = manual_drive_i;
            en_next    = manual_drive_i != `RFSC_DRIVE_ZERO;
            state_next = rfsc_pkg::RFSC_RUN;
            if (mask_go) begin
                mask_next = spin_len;
            end
            // The cycle that opens the mask may not flag a stall either.
            if (over && mask_reg == 12'h000 && !mask_go) begin
                stall_next = 1'b1;
            end
        end else if (tgt_off && target_i != tgt_d_reg) begin
            // A write of FFh stops the driver even in the middle of a
            // spin-up; the loop then waits in the run state for a target.
            state_next = rfsc_pkg::RFSC_RUN;
            en_next    = 1'b0;
            drive_next = `RFSC_DRIVE_ZERO;
        end else begin
            case (state_reg)
                rfsc_pkg::RFSC_STRAP_HOLD: begin
                    // Strap drive holds until the target is written.
                    if (target_i != tgt_d_reg) begin
                        state_next = rfsc_pkg::RFSC_RUN;
                        timer_next = {1'b0, upd_len};
                        if (mode_strap_reg == 2'h0 && !tgt_off) begin
                            state_next = rfsc_pkg::RFSC_SPIN_FULL;
                            timer_next = {2'h0, spin_len[11:2]};
                        end
                    end
                end
                rfsc_pkg::RFSC_SPIN_FULL: begin
                    // Full drive for the first quarter of the spin time.
                    drive_next = `RFSC_DRIVE_FULL;
                    en_next    = 1'b1;
                    if (timer_reg == 12'h000) begin
                        state_next = rfsc_pkg::RFSC_SPIN_LEVEL;
                        timer_next = spin_len - {2'h0, spin_len[11:2]};
                    end
                end
                rfsc_pkg::RFSC_SPIN_LEVEL: begin
                    // Chosen level for the rest, then the count is judged.
                    drive_next = spin_lvl;
                    if (timer_reg == 12'h000) begin
                        if (over) begin
                            fail_next  = 1'b1;
                            state_next = rfsc_pkg::RFSC_SPIN_FULL;
                            timer_next = {2'h0, spin_len[11:2]};
                        end else begin
                            state_next = rfsc_pkg::RFSC_RUN;
                            timer_next = {1'b0, upd_len};
                        end
                    end
                end
                default: begin
                    // Run: regulation acts only at update boundaries.
                    if (tgt_off) begin
                        en_next    = 1'b0;
                        drive_next = `RFSC_DRIVE_ZERO;
                    end else if ((tgt_d_reg == `RFSC_TARGET_OFF
                                  && target_i < valid_limit_i)
                                 || !alg_d_reg) begin
                        state_next = rfsc_pkg::RFSC_SPIN_FULL;
                        timer_next = {2'h0, spin_len[11:2]};
                    end else if (timer_reg == 12'h000) begin
                        timer_next = {1'b0, upd_len};
                        en_next    = 1'b1;
                        if (over) begin
                            stall_next = 1'b1;
                            state_next = rfsc_pkg::RFSC_SPIN_FULL;
                            timer_next = {2'h0, spin_len[11:2]};
                        end else if (meas > target_i) begin
                            // Slow fan: raise drive by at most one step.
                            drive_next = up_sum[8] ? 8'hFF : up_sum[7:0];
                        end else if (meas < target_i) begin
                            // Fast fan: lower drive, floored at minimum.
                            drive_next = dn_floor ? min_drive_i
                                                  : dn_dif[7:0];
                        end
                        if (!over && drive_next < min_drive_i) begin
                            drive_next = min_drive_i;
                        end
                    end
                    // Other target changes are used at the next update; a write of FFh, or leaving FFh below the limit, acts at once.
                end
            endcase
        end
        if (!strap_done_reg) begin
            // First cycle after reset: the drive strap picks a hold at 0%
            // or an immediate spin-up; flags and the algorithm and manual edge copies keep still.
            state_next = rfsc_pkg::RFSC_SPIN_FULL;
            if (drive_strap_i == 2'h0) begin
                state_next = rfsc_pkg::RFSC_STRAP_HOLD;
            end
            drive_next = `RFSC_DRIVE_ZERO;
            en_next    = 1'b0;
            timer_next = {2'h0, spin_len[11:2]};
            mask_next  = mask_reg;
            alg_d_next = alg_d_reg;
            man_d_next = man_d_reg;
            stall_next = stall_reg;
            fail_next  = fail_reg;
        end
    end

    // Registers control state; reset picks strap drive and spin-up.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_reg <= rfsc_pkg::RFSC_STRAP_HOLD;
            drive_reg <= `RFSC_DRIVE_ZERO;
            en_reg    <= 1'b0;
            timer_reg <= 12'h000;
            mask_reg  <= 12'h000;
            alg_d_reg <= 1'b1;
            man_d_reg <= `RFSC_DRIVE_ZERO;
            tgt_d_reg <= `RFSC_TARGET_OFF;
            stall_reg <= 1'b0;
            fail_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            drive_reg <= drive_next;
            en_reg    <= en_next;
            timer_reg <= timer_next;
            mask_reg  <= mask_next;
            alg_d_reg <= alg_d_next;
            man_d_reg <= man_d_next;
            tgt_d_reg <= tgt_d_next;
            stall_reg <= stall_next;
            fail_reg  <= fail_next;
        end
    end

    // ========================================
    // Outputs
    // ========================================
    logic [7:0] tc_reg;                // Registered tach count.

    // Registers the measured count so the port comes from a flip-flop.
    // It reads FFh until the first revolution or timeout is captured.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            tc_reg <= 8'hFF;
        end else begin
            tc_reg <= meas;
        end
    end

    assign drive_o       = drive_reg;
    assign driver_en_o   = en_reg;
    assign tach_count_o  = tc_reg;
    assign stall_o       = stall_reg;
    assign spin_fail_o   = fail_reg;
    assign ext_clk_sel_o = ext_sel_reg;
    // The interrupt follows the sticky flag; the masks act on the flag.
    assign stall_irq_o   = stall_reg;
endmodule // rfsc_fan_ctrl

/* File: hw/rfsc_consts.svh */
// Constants for the fan speed controller: levels, clock rates and timings.
`ifndef RFSC_CONSTS_SVH
`define RFSC_CONSTS_SVH
`define RFSC_TARGET_OFF    8'hFF
`define RFSC_DRIVE_FULL    8'hFF
`define RFSC_DRIVE_ZERO    8'h00
`define RFSC_DRIVE_60      8'h99
`define RFSC_DRIVE_75      8'hBF
`define RFSC_POLES_RESET   2'h1
`define RFSC_SYS_HZ        40000000
`define RFSC_TB_HZ         32768
`define RFSC_TB_DIV        ((`RFSC_SYS_HZ + `RFSC_TB_HZ - 1) / `RFSC_TB_HZ)
`define RFSC_MS_TICKS      33
`define RFSC_SPIN_250MS    12'h0FA
`define RFSC_SPIN_500MS    12'h1F4
`define RFSC_SPIN_1S       12'h3E8
`define RFSC_SPIN_2S       12'h7D0
`define RFSC_UPD_BASE      11'h064
`define RFSC_UPD_LONG      11'h640
`endif

/* File: hw/rfsc_pkg.sv */
// Types shared by the fan speed controller files.
package rfsc_pkg;
    typedef enum logic [1:0] {
        RFSC_RUN,
        RFSC_SPIN_FULL,
        RFSC_SPIN_LEVEL,
        RFSC_STRAP_HOLD
    } rfsc_state_e;
endpackage

/* File: hw/rfsc_tach_meter.sv */
// Tachometer period meter counting timebase ticks per fan revolution.
`timescale 1ns/1ps
`include "rfsc_consts.svh"
module rfsc_tach_meter (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    input  wire logic       tick_i,
    input  wire logic       tach_i,
    input  wire logic [1:0] poles_i,
    output logic [7:0]      count_o,
    output logic            done_o
);
    // ========================================
    // Edge counting and period capture
    // ========================================
    logic       tach_d_reg;            // Last tach level.
    logic       tach_d_next;           // Next tach level.
    logic [8:0] run_reg;               // Running tick count, restarts after 1FFh.
    logic [8:0] run_next;              // Next running count.
    logic [2:0] edges_reg;             // Rising edges this revolution.
    logic [2:0] edges_next;            // Next edge count.
    logic [7:0] count_reg;             // Captured count per revolution.
    logic [7:0] count_next;            // Next captured count.
    logic       done_reg;              // One-cycle capture pulse.
    logic       done_next;             // Next capture pulse.

    // Counts ticks and captures once per revolution; slow fans saturate.
    always_comb begin
        tach_d_next = tach_i;
        run_next    = run_reg;
        edges_next  = edges_reg;
        count_next  = count_reg;
        done_next   = 1'b0;
        if (tick_i && run_reg != 9'h1FF) begin
            run_next = run_reg + 9'h001;
        end
        if (tach_i && !tach_d_reg) begin
            // One edge per pole; revolution ends after poles_i + 1 edges.
            if (edges_reg == {1'b0, poles_i}) begin
                count_next = run_reg[8] ? 8'hFF : run_reg[7:0];
                done_next  = 1'b1;
                run_next   = 9'h000;
                edges_next = 3'h0;
            end else begin
                edges_next = edges_reg + 3'h1;
            end
        end else if (run_reg == 9'h1FF && tick_i) begin
            // Stopped fan: report the largest count.
            count_next = 8'hFF;
            done_next  = 1'b1;
            run_next   = 9'h000;
            edges_next = 3'h0;
        end
    end

    // Registers the meter state.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            tach_d_reg <= 1'b1; // Idle high, so no edge follows reset.
            run_reg    <= 9'h000;
            edges_reg  <= 3'h0;
            count_reg  <= 8'hFF;
            done_reg   <= 1'b0;
        end else begin
            tach_d_reg <= tach_d_next;
            run_reg    <= run_next;
            edges_reg  <= edges_next;
            count_reg  <= count_next;
            done_reg   <= done_next;
        end
    end

    assign count_o = count_reg;
    assign done_o  = done_reg;
endmodule // rfsc_tach_meter

/* File: testbench/rfsc_fan_ctrl_props.sv */
// Concurrent checks on the fan speed controller's ports.
`timescale 1ns/1ps
module rfsc_fan_ctrl_chk (
    input wire logic       clk_sys_i,
    input wire logic       reset_i,
    input wire logic       alg_en_i,
    input wire logic [7:0] manual_drive_i,
    input wire logic       stall_clear_i,
    input wire logic       spin_fail_clear_i,
    input wire logic [7:0] drive_o,
    input wire logic       driver_en_o,
    input wire logic [7:0] tach_count_o,
    input wire logic       stall_o,
    input wire logic       spin_fail_o,
    input wire logic       ext_clk_sel_o,
    input wire logic       stall_irq_o
);
    // ========================================
    // Sequences and clocking
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // One cycle spent in manual mode.
    sequence manual_cyc;
        !alg_en_i;
    endsequence
    // Eight cycles in which the interrupt does not rise.
    sequence no_irq_rise;
        (!$rose(stall_irq_o)) [*8];
    endsequence
    // ========================================
    // Assertions
    reset_vals_a: assert property (disable iff (1'b0) reset_i |=>
        drive_o == 8'h00 && !driver_en_o && !stall_o && !spin_fail_o
        && tach_count_o == 8'hFF) else $error("reset values wrong");
    manual_drive_a: assert property (manual_cyc |=>
        drive_o == $past(manual_drive_i)) else $error("manual drive lost");
    manual_off_a: assert property (manual_cyc |=>
        driver_en_o == ($past(manual_drive_i) != 8'h00))
        else $error("driver enable wrong in manual mode");
    clk_sel_hold_a: assert property ($past(!reset_i) |=>
        $stable(ext_clk_sel_o)) else $error("clock choice changed");
    stall_sticky_a: assert property (stall_o && !stall_clear_i |=>
        stall_o) else $error("stall flag dropped without clear");
    fail_sticky_a: assert property (spin_fail_o && !spin_fail_clear_i
        |=> spin_fail_o) else $error("spin failure flag dropped");
    enter_mask_a: assert property ($fell(alg_en_i) |-> ##1 no_irq_rise)
        else $error("stall interrupt on entering manual mode");
    leave_zero_mask_a: assert property (!alg_en_i
        && $past(manual_drive_i) == 8'h00 && manual_drive_i != 8'h00
        |-> ##1 no_irq_rise) else $error("stall interrupt after leaving 00");
endmodule // rfsc_fan_ctrl_chk
bind rfsc_fan_ctrl rfsc_fan_ctrl_chk rfsc_fan_ctrl_chk_inst (.clk_sys_i,
    .reset_i, .alg_en_i, .manual_drive_i, .stall_clear_i, .spin_fail_clear_i,
    .drive_o, .driver_en_o, .tach_count_o, .stall_o, .spin_fail_o,
    .ext_clk_sel_o, .stall_irq_o);

/* File: testbench/rfsc_fan_model.sv */
// Behavioural three-wire fan whose tach output feeds the controller.
`timescale 1ns/1ps
module rfsc_fan_model #(
    parameter int HALF = 16
) (
    input  wire logic       clk_sys_i,
    input  wire logic       driver_en_i,
    input  wire logic [7:0] drive_i,
    input  wire logic       stall_i,
    output logic            tach_o
);
    int   cnt_reg  = 0;    // Cycles into the current tach half period.
    int   cnt_next;        // Next value of the half period counter.
    logic tach_reg = 1'b1; // Tach level; pulled up while the fan stands.
    logic tach_next;       // Next tach level.
    // A driven, free fan toggles tach each HALF cycles; else it rests high.
    always_comb begin
        cnt_next  = cnt_reg + 1;
        tach_next = tach_reg;
        if (!driver_en_i || drive_i == 8'h00 || stall_i) begin
            cnt_next  = 0;
            tach_next = 1'b1;
        end else if (cnt_reg == HALF - 1) begin
            cnt_next  = 0;
            tach_next = ~tach_reg;
        end
    end
    // Registers the fan state.
    always_ff @(posedge clk_sys_i) begin
        cnt_reg  <= cnt_next;
        tach_reg <= tach_next;
    end
    assign tach_o = tach_reg;
endmodule // rfsc_fan_model

/* File: testbench/rfsc_fan_ctrl_bench.sv */
// Self-checking bench for the fan speed controller.
`timescale 1ns/1ps
module rfsc_fan_ctrl_bench;
    logic       clk_sys_i, reset_i, ext_tb_i, alg_en_i, tach_w, fan_stall;
    logic       spin_level_75_i, stall_clear_i, spin_fail_clear_i;
    logic [1:0] drive_strap_i, spin_time_i, poles_i;
    logic       clk_strap_i;
    logic [2:0] update_sel_i;
    logic [7:0] target_i, valid_limit_i, manual_drive_i, step_i, min_drive_i;
    logic [7:0] drive_o, tach_count_o;
    logic       driver_en_o, stall_o, spin_fail_o, ext_clk_sel_o, stall_irq_o;
    int         mismatches, check_count, cycles;
    rfsc_fan_ctrl rfsc_fan_ctrl_inst (.clk_sys_i, .reset_i,
        .clk_strap_i, .ext_tb_i, .drive_strap_i, .tach_i(tach_w),
        .alg_en_i, .target_i, .valid_limit_i, .manual_drive_i,
        .spin_level_75_i, .spin_time_i, .step_i, .min_drive_i, .update_sel_i,
        .poles_i, .stall_clear_i, .spin_fail_clear_i, .drive_o, .driver_en_o,
        .tach_count_o, .stall_o, .spin_fail_o, .ext_clk_sel_o, .stall_irq_o);
    rfsc_fan_model rfsc_fan_model_inst (.clk_sys_i, .driver_en_i(driver_en_o),
        .drive_i(drive_o), .stall_i(fan_stall), .tach_o(tach_w));
    // ========================================
    // Clock, fast external timebase and hang guard
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    always @(negedge clk_sys_i) ext_tb_i <= ~ext_tb_i;
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 99000) begin
            mismatches++;
            final_report();
        end
    end
    // ========================================
    // Shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask
    task automatic wait_drive(input logic [7:0] exp, input int lim);
        for (int n = 0; n < lim && drive_o !== exp; n++) @(negedge clk_sys_i);
        chk(drive_o, exp, "drive level");
    endtask
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ========================================
    // Main sequence: algorithm first, then manual mode.
    initial begin
        {reset_i, alg_en_i, ext_tb_i, fan_stall} = 4'b1100;
        clk_strap_i = 1'b1;
        {spin_level_75_i, stall_clear_i, spin_fail_clear_i} = 3'b000;
        {drive_strap_i, spin_time_i, poles_i, update_sel_i} = 9'h001 << 3;
        {target_i, valid_limit_i, manual_drive_i} = {8'hFF, 8'hFF, 8'h00};
        {step_i, min_drive_i, mismatches, check_count, cycles} = '0;
        repeat (12) @(negedge clk_sys_i);
        chk(tach_count_o, 8'hFF, "reset count");
        reset_i = 1'b0;
        repeat (100) @(negedge clk_sys_i);
        chk({7'h00, ext_clk_sel_o}, 8'h01, "clock choice");
        chk({7'h00, driver_en_o}, 8'h00, "zero strap hold");
        valid_limit_i = 8'hF0;
        step_i = 8'h10;
        min_drive_i = 8'h40;
        target_i = 8'h20;
        wait_drive(8'hFF, 400);
        repeat (5000) @(negedge clk_sys_i);
        chk(drive_o, 8'h99, "spin level");
        repeat (19000) @(negedge clk_sys_i);
        chk({7'h00, drive_o >= 8'h40}, 8'h01, "minimum drive");
        chk({7'h00, tach_count_o < 8'hF0}, 8'h01, "valid count");
        chk({7'h00, stall_o}, 8'h00, "no stall");
        fan_stall = 1'b1;
        wait_drive(8'hFF, 9000);
        chk({7'h00, stall_o}, 8'h01, "stall flag");
        for (int n = 0; n < 20000 && !spin_fail_o; n++) @(negedge clk_sys_i);
        chk({7'h00, spin_fail_o}, 8'h01, "spin failure");
        wait_drive(8'hFF, 400);
        target_i = 8'hFF;
        for (int n = 0; n < 8000 && driver_en_o; n++) @(negedge clk_sys_i);
        chk({7'h00, driver_en_o}, 8'h00, "target off");
        target_i = 8'h20;
        wait_drive(8'hFF, 4);
        target_i = 8'hFF;
        repeat (2) @(negedge clk_sys_i);
        chk({7'h00, driver_en_o}, 8'h00, "target off again");
        alg_en_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        chk({7'h00, driver_en_o}, 8'h00, "manual zero");
        stall_clear_i = 1'b1;
        @(negedge clk_sys_i);
        stall_clear_i = 1'b0;
        manual_drive_i = 8'h80;
        repeat (2) @(negedge clk_sys_i);
        chk(drive_o, 8'h80, "manual drive");
        repeat (2000) @(negedge clk_sys_i);
        chk({7'h00, stall_irq_o}, 8'h00, "masked interrupt");
        repeat (18000) @(negedge clk_sys_i);
        chk({6'h00, stall_o, stall_irq_o}, 8'h03, "manual stall");
        // Second reset: internal timebase and a 75% strap that spins up.
        {reset_i, alg_en_i, clk_strap_i, drive_strap_i} = 5'b11010;
        repeat (3) @(negedge clk_sys_i);
        reset_i = 1'b0;
        wait_drive(8'hFF, 4);
        chk({7'h00, ext_clk_sel_o}, 8'h00, "internal clock");
        final_report();
    end
endmodule // rfsc_fan_ctrl_bench
